// file: verilog/cic_core.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cic_core (
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   // AXI4-Lite slave.
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [3:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   output logic [1:0]       s_axi_bresp_o,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   input  wire logic [3:0]  s_axi_araddr_i,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   // Routine entry.
   output logic             isr_entry_o,
   // Controller side.
   cic_if.core              bus
);
   logic [3:0]            aw_addr;
   logic [31:0]           w_data;
   logic [3:0]            w_strb;
   logic                  wr_fire;
   logic                  cmd_ok;
   logic                  cmd_go;
   logic                  ar_fire;
   logic [31:0]           rd_word;
   logic                  rd_ok;
   cic_pkg::cic_core_st_t st;
   logic [2:0]            call_cnt;
   logic                  rd_wait;
   logic [7:0]            sfr_data;
   logic [4:0]            last_num;
   logic [7:0]            last_vec;
   logic [15:0]           entry_cnt;

   assign wr_fire = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
   assign cmd_ok  = (aw_addr == cic_pkg::REG_CMD) && (w_strb == 4'hf);
   assign cmd_go  = wr_fire && cmd_ok;
   assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;
   assign rd_ok   = (s_axi_araddr_i == cic_pkg::REG_STAT) || (s_axi_araddr_i == cic_pkg::REG_SFRD)
                 || (s_axi_araddr_i == cic_pkg::REG_CNT);
   assign rd_word = (s_axi_araddr_i == cic_pkg::REG_STAT)
                  ? {8'h00, last_vec, 3'h0, last_num, 6'h00, rd_wait, st == cic_pkg::CIC_CALL}
                  : (s_axi_araddr_i == cic_pkg::REG_SFRD) ? {24'h000000, sfr_data}
                  : (s_axi_araddr_i == cic_pkg::REG_CNT) ? {16'h0000, entry_cnt} : 32'h00000000;

   // Address and data are taken in either order; the response follows both.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= cic_pkg::RESP_OKAY;
         aw_addr         <= 4'h0;
         w_data          <= 32'h00000000;
         w_strb          <= 4'h0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr         <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= cmd_ok ? cic_pkg::RESP_OKAY : cic_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h00000000;
         s_axi_rresp_o   <= cic_pkg::RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= rd_word;
         s_axi_rresp_o   <= rd_ok ? cic_pkg::RESP_OKAY : cic_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // Firmware ordering (clear flags, global enable, source enables, local
   // masks) is carried by software through these commands.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus.sfr_wr    <= 1'b0;
         bus.sfr_rd    <= 1'b0;
         bus.irq_ret   <= 1'b0;
         bus.sfr_addr  <= 4'h0;
         bus.sfr_wdata <= 8'h00;
         rd_wait       <= 1'b0;
         sfr_data      <= 8'h00;
      end else begin
         bus.sfr_wr  <= cmd_go && w_data[cic_pkg::CMD_WR_BIT];
         bus.sfr_rd  <= cmd_go && w_data[cic_pkg::CMD_RD_BIT];
         bus.irq_ret <= cmd_go && w_data[cic_pkg::CMD_RET_BIT];
         if (cmd_go) begin
            bus.sfr_addr  <= w_data[cic_pkg::CMD_ADDR_LSB +: 4];
            bus.sfr_wdata <= w_data[cic_pkg::CMD_DATA_LSB +: 8];
         end
         rd_wait <= bus.sfr_rd;
         if (rd_wait) begin
            sfr_data <= bus.sfr_rdata;
         end
      end
   end

   // One detect cycle carries the acknowledge, then six for the call.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st          <= cic_pkg::CIC_IDLE;
         call_cnt    <= 3'h0;
         bus.irq_ack <= 1'b0;
         last_num    <= 5'h00;
         last_vec    <= 8'h00;
         entry_cnt   <= 16'h0000;
         isr_entry_o <= 1'b0;
      end else begin
         bus.irq_ack <= (st == cic_pkg::CIC_IDLE) && bus.irq_req && !bus.irq_ack;
         isr_entry_o <= 1'b0;
         unique case (st)
            cic_pkg::CIC_IDLE: begin
               if (bus.irq_ack && bus.irq_req) begin
                  st       <= cic_pkg::CIC_CALL;
                  call_cnt <= 3'h0;
                  last_num <= bus.irq_num;
                  last_vec <= bus.irq_vec;
               end
            end
            cic_pkg::CIC_CALL: begin
               if (call_cnt == 3'(cic_pkg::MC_CALL - 1)) begin
                  st          <= cic_pkg::CIC_IDLE;
                  isr_entry_o <= 1'b1;
                  entry_cnt   <= entry_cnt + 16'h0001;
               end else begin
                  call_cnt <= call_cnt + 3'h1;
               end
            end
         endcase
      end
   end
endmodule

// file: include/cic_pkg.sv
package cic_pkg;
   localparam int NUM_SRC = 18;
   localparam int NUM_GRP = 6;
   localparam int NUM_LVL = 4;
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam int GIE_BIT = 7;
   // Register indices on the core side register port.
   localparam logic [3:0] SFR_EN_A = 4'h0;
   localparam logic [3:0] SFR_EN_B = 4'h1;
   localparam logic [3:0] SFR_EN_C = 4'h2;
   localparam logic [3:0] SFR_FL_TMR = 4'h3;
   localparam logic [3:0] SFR_FL_SER_A = 4'h4;
   localparam logic [3:0] SFR_FL_SER_B = 4'h5;
   localparam logic [3:0] SFR_FL_A = 4'h6;
   localparam logic [3:0] SFR_FL_B = 4'h7;
   localparam logic [3:0] SFR_PRIO_LO = 4'h8;
   localparam logic [3:0] SFR_PRIO_HI = 4'h9;
   localparam logic [3:0] SFR_SVC = 4'ha;
   // Source map, index order 0 to 17.
   localparam logic [3:0] SRC_EN_REG [0:17] = '{
      SFR_EN_A, SFR_EN_A, SFR_EN_A, SFR_EN_A, SFR_EN_A, SFR_EN_A, SFR_EN_C, SFR_EN_C,
      SFR_EN_B, SFR_EN_B, SFR_EN_B, SFR_EN_B, SFR_EN_B, SFR_EN_B, SFR_EN_C, SFR_EN_C,
      SFR_EN_C, SFR_EN_C};
   localparam logic [2:0] SRC_EN_BIT [0:17] = '{
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};
   localparam logic [3:0] SRC_FL_REG [0:17] = '{
      SFR_FL_TMR, SFR_FL_TMR, SFR_FL_TMR, SFR_FL_TMR, SFR_FL_SER_A, SFR_FL_A,
      SFR_FL_B, SFR_FL_B, SFR_FL_A, SFR_FL_A, SFR_FL_A, SFR_FL_A, SFR_FL_A, SFR_FL_A,
      SFR_FL_B, SFR_FL_B, SFR_FL_SER_B, SFR_FL_B};
   localparam logic [2:0] SRC_FL_BIT [0:17] = '{
      3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h6, 3'h0, 3'h1, 3'h0,
      3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h2, 3'h3, 3'h0, 3'h4};
   // Core timing in machine cycles, one machine cycle per clock.
   localparam int MC_DETECT = 1;
   localparam int MC_CALL = 6;
   // Core command registers, byte offsets.
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_SFRD = 4'h8;
   localparam logic [3:0] REG_CNT = 4'hc;
   localparam int CMD_WR_BIT = 0;
   localparam int CMD_RD_BIT = 1;
   localparam int CMD_RET_BIT = 2;
   localparam int CMD_ADDR_LSB = 8;
   localparam int CMD_DATA_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic {CIC_IDLE, CIC_CALL} cic_core_st_t;

   function automatic logic [7:0] cic_vector(input logic [4:0] n);
      return VEC_BASE + {n, 3'h0};
   endfunction

   function automatic logic [1:0] cic_top(input logic [3:0] svc);
      logic [1:0] t;
      t = 2'h0;
      for (int i = 0; i < NUM_LVL; i++) begin
         if (svc[i]) begin
            t = 2'(i);
         end
      end
      return t;
   endfunction
endpackage

// file: include/cic_if.sv
`timescale 1ns/1ps
interface cic_if;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [3:0] sfr_addr;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       irq_req;
   logic [4:0] irq_num;
   logic [7:0] irq_vec;
   logic       irq_ack;
   logic       irq_ret;
   modport ctl (
      input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack, irq_ret,
      output sfr_rdata, irq_req, irq_num, irq_vec
   );
   modport core (
      output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, irq_ack, irq_ret,
      input  sfr_rdata, irq_req, irq_num, irq_vec
   );
endinterface

// file: verilog/cic_arb.sv
`timescale 1ns/1ps
module cic_arb (
   // Eligible requests and their levels.
   input  wire logic [17:0] req_i,
   input  wire logic [35:0] lvl_i,
   // Winner.
   output logic             found_o,
   output logic [4:0]       num_o
);
   logic [1:0] best;

   // Scanning downward with >= lets the lowest number win a tie.
   always_comb begin
      found_o = 1'b0;
      num_o   = 5'h00;
      best    = 2'h0;
      for (int i = 17; i >= 0; i--) begin
         if (req_i[i] && (!found_o || lvl_i[2*i +: 2] >= best)) begin
            found_o = 1'b1;
            num_o   = 5'(i);
            best    = lvl_i[2*i +: 2];
         end
      end
   end
endmodule

// file: verilog/cic_ctl.sv
`timescale 1ns/1ps
module cic_ctl (
   // Clock and reset.
   input  wire logic        mclk_i,
   input  wire logic        nrst_i,
   // Peripheral request lines.
   input  wire logic [17:0] src_evt_i,
   input  wire logic        wdt_timer_mode_i,
   // Status.
   output logic             global_irq_enable_o,
   output logic [3:0]       svc_level_o,
   // Core side.
   cic_if.ctl               bus
);
   localparam int N = cic_pkg::NUM_SRC;

   logic [N-1:0]   evt;
   logic [N-1:0]   flag;
   logic [N-1:0]   en;
   logic [N-1:0]   next_flag;
   logic [N-1:0]   next_en;
   logic [N-1:0]   fl_wr;
   logic [N-1:0]   en_wr;
   logic [N-1:0]   pend;
   logic [N-1:0]   elig;
   logic [2*N-1:0] lvl;
   logic [5:0]     prio_lo;
   logic [5:0]     prio_hi;
   logic           svc_any;
   logic [1:0]     cur_lvl;
   logic [1:0]     ack_lvl;
   logic           ack_take;
   logic [3:0]     next_svc;
   logic           arb_found;
   logic [4:0]     arb_num;
   logic [7:0]     rd_byte;
   logic           gie_wr;
   logic           lo_wr;
   logic           hi_wr;

   // Multi-event peripherals already combine and mask their events.
   // The watchdog only counts while it runs as a plain timer.
   assign evt = {src_evt_i[N-1] & wdt_timer_mode_i, src_evt_i[N-2:0]};

   for (genvar gi = 0; gi < N; gi++) begin : g_src
      assign fl_wr[gi] = bus.sfr_wr && (bus.sfr_addr == cic_pkg::SRC_FL_REG[gi]);
      assign en_wr[gi] = bus.sfr_wr && (bus.sfr_addr == cic_pkg::SRC_EN_REG[gi]);
      // An event in the cycle of a clearing write still sets the flag.
      assign next_flag[gi] = evt[gi]
                           | (fl_wr[gi] ? bus.sfr_wdata[cic_pkg::SRC_FL_BIT[gi]] : flag[gi]);
      assign next_en[gi] = en_wr[gi] ? bus.sfr_wdata[cic_pkg::SRC_EN_BIT[gi]] : en[gi];
      assign lvl[2*gi +: 2] = {prio_hi[gi % cic_pkg::NUM_GRP], prio_lo[gi % cic_pkg::NUM_GRP]};
      // A running service is only left for a strictly higher level.
      assign elig[gi] = pend[gi] && (!svc_any || lvl[2*gi +: 2] > cur_lvl);
   end

   assign gie_wr = bus.sfr_wr && (bus.sfr_addr == cic_pkg::SFR_EN_A);
   assign lo_wr  = bus.sfr_wr && (bus.sfr_addr == cic_pkg::SFR_PRIO_LO);
   assign hi_wr  = bus.sfr_wr && (bus.sfr_addr == cic_pkg::SFR_PRIO_HI);

   // Nothing is offered after the first cycle that the global enable is low.
   assign pend = flag & en & {N{global_irq_enable_o}};

   assign svc_any  = |svc_level_o;
   assign cur_lvl  = cic_pkg::cic_top(svc_level_o);
   assign ack_lvl  = lvl[{bus.irq_num, 1'b0} +: 2];
   assign ack_take = bus.irq_ack && bus.irq_req;

   cic_arb u_arb (
      .req_i   (elig),
      .lvl_i   (lvl),
      .found_o (arb_found),
      .num_o   (arb_num)
   );

   // A return closes the highest level in service before a new one opens.
   always_comb begin
      next_svc = svc_level_o;
      if (bus.irq_ret && svc_any) begin
         next_svc[cur_lvl] = 1'b0;
      end
      if (ack_take) begin
         next_svc[ack_lvl] = 1'b1;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < N; i++) begin
         if (bus.sfr_addr == cic_pkg::SRC_FL_REG[i]) begin
            rd_byte[cic_pkg::SRC_FL_BIT[i]] = flag[i];
         end
         if (bus.sfr_addr == cic_pkg::SRC_EN_REG[i]) begin
            rd_byte[cic_pkg::SRC_EN_BIT[i]] = en[i];
         end
      end
      if (bus.sfr_addr == cic_pkg::SFR_EN_A) begin
         rd_byte[cic_pkg::GIE_BIT] = global_irq_enable_o;
      end
      if (bus.sfr_addr == cic_pkg::SFR_PRIO_LO) begin
         rd_byte = {2'h0, prio_lo};
      end
      if (bus.sfr_addr == cic_pkg::SFR_PRIO_HI) begin
         rd_byte = {2'h0, prio_hi};
      end
      if (bus.sfr_addr == cic_pkg::SFR_SVC) begin
         rd_byte = {4'h0, svc_level_o};
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag <= '0;
         en   <= '0;
      end else begin
         flag <= next_flag;
         en   <= next_en;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         global_irq_enable_o <= 1'b0;
         prio_lo             <= 6'h00;
         prio_hi             <= 6'h00;
      end else begin
         if (gie_wr) begin
            global_irq_enable_o <= bus.sfr_wdata[cic_pkg::GIE_BIT];
         end
         if (lo_wr) begin
            prio_lo <= bus.sfr_wdata[5:0];
         end
         if (hi_wr) begin
            prio_hi <= bus.sfr_wdata[5:0];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         svc_level_o   <= 4'h0;
         bus.sfr_rdata <= 8'h00;
      end else begin
         svc_level_o <= next_svc;
         if (bus.sfr_rd) begin
            bus.sfr_rdata <= rd_byte;
         end
      end
   end

   // The request drops in the cycle after an acknowledge so that the
   // level just opened is seen before the next offer is made.
   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus.irq_req <= 1'b0;
         bus.irq_num <= 5'h00;
         bus.irq_vec <= cic_pkg::VEC_BASE;
      end else begin
         bus.irq_req <= arb_found && !ack_take;
         if (arb_found) begin
            bus.irq_num <= arb_num;
            bus.irq_vec <= cic_pkg::cic_vector(arb_num);
         end
      end
   end
endmodule

// file: test/cic_monitor.sv
`timescale 1ns/1ps
module cic_monitor (
   // Clock and reset.
   input wire logic       mclk_i,
   input wire logic       nrst_i,
   // Watched signals.
   input wire logic       irq_req_i,
   input wire logic [4:0] irq_num_i,
   input wire logic [7:0] irq_vec_i,
   input wire logic       irq_ack_i,
   input wire logic       irq_ret_i,
   input wire logic       global_irq_enable_i,
   input wire logic [3:0] svc_level_i,
   input wire logic       isr_entry_i
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_vec_map;
      irq_req_i |-> irq_vec_i == 8'h03 + {irq_num_i, 3'h0};
   endproperty
   a_vec_map: assert property (p_vec_map) else $error("vector off");
   property p_num_range;
      irq_req_i |-> irq_num_i <= 5'h11;
   endproperty
   a_num_range: assert property (p_num_range) else $error("number off");
   // Two low samples so that a request launched before the clear may still end.
   property p_gie_block;
      !global_irq_enable_i && $past(!global_irq_enable_i) |-> !irq_req_i;
   endproperty
   a_gie_block: assert property (p_gie_block) else $error("request while off");
   property p_ack_drop;
      irq_ack_i && irq_req_i |=> !irq_req_i;
   endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("request held");
   property p_ack_gap;
      irq_ack_i |=> !irq_ack_i [*6];
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("ack too soon");
   property p_ack_entry;
      irq_ack_i && irq_req_i |-> ##[7:8] isr_entry_i;
   endproperty
   a_ack_entry: assert property (p_ack_entry) else $error("entry late");
   property p_svc_rise;
      (svc_level_i & ~$past(svc_level_i)) != 4'h0 |-> $past(irq_ack_i && irq_req_i);
   endproperty
   a_svc_rise: assert property (p_svc_rise) else $error("service bit unasked");
   property p_ret_drop;
      irq_ret_i && !irq_ack_i && svc_level_i != 4'h0
         |=> $countones(svc_level_i) + 1 == $countones($past(svc_level_i));
   endproperty
   a_ret_drop: assert property (p_ret_drop) else $error("return kept level");

   c_ack: cover property (irq_ack_i && irq_req_i);
   c_preempt: cover property (irq_ack_i && irq_req_i && svc_level_i != 4'h0);
   c_ret: cover property (irq_ret_i && svc_level_i != 4'h0);
endmodule

// file: test/tb_cpu_interrupt_controller.sv
`timescale 1ns/1ps
module tb_cpu_interrupt_controller;
   logic        mclk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic [17:0] evt = 18'h0;
   logic        wdt = 1'b1;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic [3:0]  awa = 4'h0, ara = 4'h0, stb = 4'hf;
   logic [31:0] wd = 32'h0;
   logic        awr, wrdy, bv, arr, rv, isr, gie;
   logic [1:0]  br, rr, rsp;
   logic [31:0] rdat, rd, r, seed = 32'h340a3724;
   logic [3:0]  svc;
   logic [7:0]  b, ev;
   logic [5:0]  lo, hi;
   int          num_errors = 0, checks_done = 0, cycles = 0, entries = 0;
   int          a, o, win, los, c;
   cic_if bus_if ();

   cic_ctl cic_ctl_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .src_evt_i(evt),
      .wdt_timer_mode_i(wdt), .global_irq_enable_o(gie), .svc_level_o(svc), .bus(bus_if));
   cic_core cic_core_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(stb), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_bresp_o(br), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
      .s_axi_rready_i(rry), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr),
      .isr_entry_o(isr), .bus(bus_if));
   cic_monitor cic_monitor_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .irq_req_i(bus_if.irq_req),
      .irq_num_i(bus_if.irq_num), .irq_vec_i(bus_if.irq_vec), .irq_ack_i(bus_if.irq_ack),
      .irq_ret_i(bus_if.irq_ret), .global_irq_enable_i(gie), .svc_level_i(svc),
      .isr_entry_i(isr));

   function automatic logic [31:0] xr();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] vec_of(input int n);
      return 8'h03 + 8'(8 * n);
   endfunction
   function automatic logic [1:0] lvl(input int n);
      return {hi[n % 6], lo[n % 6]};
   endfunction

   task automatic report_and_stop();
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic axi_wr(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge mclk_i);
      awv <= 1'b1;
      awa <= ad;
      wv <= 1'b1;
      wd <= d;
      stb <= s;
      bry <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrdy) wv <= 1'b0;
      end while (!(bv && bry));
      rsp = br;
      bry <= 1'b0;
   endtask
   task automatic axi_rd(input logic [3:0] ad);
      @(posedge mclk_i);
      arv <= 1'b1;
      ara <= ad;
      rry <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (arv && arr) arv <= 1'b0;
      end while (!(rv && rry));
      rd = rdat;
      rsp = rr;
      rry <= 1'b0;
   endtask
   task automatic sfr_w(input logic [3:0] idx, input logic [7:0] v);
      axi_wr(cic_pkg::REG_CMD, {8'h00, v, 4'h0, idx, 8'h01});
   endtask
   task automatic sfr_r(input logic [3:0] idx);
      axi_wr(cic_pkg::REG_CMD, {16'h0000, 4'h0, idx, 8'h02});
      repeat (2) @(posedge mclk_i);
      axi_rd(cic_pkg::REG_SFRD);
      b = rd[7:0];
   endtask
   // Two edges so that the cleared service level has landed before it is read.
   task automatic ret();
      axi_wr(cic_pkg::REG_CMD, 32'h00000004);
      repeat (2) @(posedge mclk_i);
   endtask
   task automatic fire(input logic [17:0] m);
      @(posedge mclk_i);
      evt <= m;
      @(posedge mclk_i);
      evt <= 18'h0;
   endtask
   task automatic wait_isr(input int n);
      int k;
      k = 0;
      while (isr !== 1'b1 && k < 80) begin
         @(posedge mclk_i);
         k++;
      end
      entries++;
      chk("entry", 1, isr);
      axi_rd(cic_pkg::REG_STAT);
      chk("number", n, rd[12:8]);
      chk("vector", vec_of(n), rd[23:16]);
      chk("stat idle", 2'h0, rd[1:0]);
   endtask

   always #4 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      nrst_i <= 1'b1;
      chk("global", 0, gie);
      sfr_r(cic_pkg::SFR_EN_A);
      chk("enable a", 0, b);
      axi_wr(4'h4, 32'h0);
      chk("bresp", cic_pkg::RESP_SLVERR, rsp);
      axi_wr(cic_pkg::REG_CMD, 32'h1, 4'h3);
      chk("bresp", cic_pkg::RESP_SLVERR, rsp);
      axi_rd(4'h2);
      chk("rresp", cic_pkg::RESP_SLVERR, rsp);
      for (a = 0; a < 18; a++) begin
         ev = 8'h01 << cic_pkg::SRC_EN_BIT[a];
         sfr_w(cic_pkg::SRC_FL_REG[a], 8'h00);
         sfr_w(cic_pkg::SFR_EN_A, 8'h80);
         if (a == 17) begin
            wdt <= 1'b0;
            fire(18'h20000);
            sfr_r(cic_pkg::SRC_FL_REG[a]);
            chk("watchdog flag", 0, b[cic_pkg::SRC_FL_BIT[a]]);
            wdt <= 1'b1;
         end
         fire(18'h1 << a);
         repeat (6) @(posedge mclk_i);
         chk("request", 0, bus_if.irq_req);
         sfr_r(cic_pkg::SRC_FL_REG[a]);
         chk("flag", 1, b[cic_pkg::SRC_FL_BIT[a]]);
         if (cic_pkg::SRC_EN_REG[a] == cic_pkg::SFR_EN_A) ev = ev | 8'h80;
         sfr_w(cic_pkg::SRC_EN_REG[a], ev);
         wait_isr(a);
         chk("service", 4'h1, svc);
         sfr_w(cic_pkg::SRC_FL_REG[a], 8'h00);
         sfr_w(cic_pkg::SRC_EN_REG[a], 8'h00);
         ret();
         chk("service", 4'h0, svc);
      end
      // The first pass keeps every group at one level, so only the number decides.
      for (c = 0; c < 6; c++) begin
         r = xr();
         lo = (c == 0) ? 6'h00 : r[5:0];
         hi = (c == 0) ? 6'h00 : r[11:6];
         a = r[20:16] % 18;
         o = (a + 1 + r[27:24] % 17) % 18;
         sfr_w(cic_pkg::SFR_PRIO_LO, {2'h0, lo});
         sfr_w(cic_pkg::SFR_PRIO_HI, {2'h0, hi});
         sfr_w(cic_pkg::SFR_EN_A, 8'h3f);
         sfr_w(cic_pkg::SFR_EN_B, 8'h3f);
         sfr_w(cic_pkg::SFR_EN_C, 8'h3f);
         fire((18'h1 << a) | (18'h1 << o));
         repeat (6) @(posedge mclk_i);
         chk("request", 0, bus_if.irq_req);
         sfr_w(cic_pkg::SFR_EN_A, 8'hbf);
         win = (lvl(o) > lvl(a) || (lvl(o) == lvl(a) && o < a)) ? o : a;
         los = a + o - win;
         wait_isr(win);
         chk("global", 1, gie);
         ev = 8'h01 << cic_pkg::SRC_FL_BIT[los];
         if (cic_pkg::SRC_FL_REG[los] != cic_pkg::SRC_FL_REG[win]) ev = 8'h00;
         sfr_w(cic_pkg::SRC_FL_REG[win], ev);
         repeat (12) @(posedge mclk_i);
         chk("service", 4'h1 << lvl(win), svc);
         ret();
         wait_isr(los);
         sfr_w(cic_pkg::SRC_FL_REG[los], 8'h00);
         ret();
         chk("service", 4'h0, svc);
      end
      sfr_w(cic_pkg::SFR_EN_C, 8'h00);
      sfr_w(cic_pkg::SFR_PRIO_LO, 8'h08);
      sfr_w(cic_pkg::SFR_PRIO_HI, 8'h08);
      sfr_w(cic_pkg::SFR_EN_A, 8'ha0);
      sfr_w(cic_pkg::SFR_EN_B, 8'h02);
      fire(18'h00020);
      wait_isr(5);
      fire(18'h00200);
      wait_isr(9);
      chk("service", 4'h9, svc);
      sfr_w(cic_pkg::SFR_FL_A, 8'h00);
      ret();
      chk("service", 4'h1, svc);
      ret();
      chk("service", 4'h0, svc);
      axi_rd(cic_pkg::REG_CNT);
      chk("entries", entries, rd[15:0]);
      // A reset in mid-run must drop the global enable that software had set.
      nrst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      nrst_i <= 1'b1;
      @(posedge mclk_i);
      chk("global", 0, gie);
      chk("service", 4'h0, svc);
      chk("request", 0, bus_if.irq_req);
      sfr_r(cic_pkg::SFR_EN_A);
      chk("enable a", 0, b);
      report_and_stop();
   end
endmodule
